/* File: shared/per_pkg.sv */
// Purpose: Constants for the protection error response block.
// Assumes: Byte-wide response words written and queried by command.
// Notes:   Bit positions are shared by both response words.
package per_pkg;
    // Response word bit positions
    localparam int BIT_FIX_LIMIT   = 7;
    localparam int BIT_PROT_EN     = 6;
    localparam int BIT_ESR_EN      = 5;
    localparam int BIT_ESE_INIT    = 4;
    localparam int BIT_MSG_EN      = 3;
    localparam int BIT_PROT_OFF    = 2;
    localparam int BIT_MEAS_MSG    = 1;
    localparam int BIT_MEAS_OFF    = 0;
    // Reset and power-up values
    localparam logic [7:0] RESP_RESET     = 8'h00;
    localparam logic [7:0] LIMIT_RESET    = 8'h00;
    localparam logic [7:0] ESE_INIT_PROT  = 8'h48;
    localparam logic [7:0] ESE_INIT_PLAIN = 8'h08;
    // Error message numbers
    localparam logic [9:0] MSG_CURR_PROT  = 10'h12f;
    localparam logic [9:0] MSG_VOLT_PROT  = 10'h130;
    // Command select codes
    localparam logic [1:0] SEL_CURR_RESP  = 2'h0;
    localparam logic [1:0] SEL_VOLT_RESP  = 2'h1;
    localparam logic [1:0] SEL_ON_LIMIT   = 2'h2;
endpackage : per_pkg

/* File: design/per_top.sv */
// Purpose: Holds the current and voltage fault response words and turns detected
//          faults into status flags, queued messages and output shutdown.
// Assumes: Fault inputs are one-cycle pulses on i_clk_sys from the power stage logic.
// Notes:   Words are volatile; reset restores zero until a saved copy is reloaded.

// Summary of operation
// - Two byte response words, current and voltage, any value, reset to zero.
// - Current bit 7 applies the fixed current limit while output is on.
// - Current bit 6 enables current protection fault detection.
// - Current bit 5 flags current protection faults in event status bit.
// - Current bit 4 loads event enable 72 or 8 on an init request.
// - Current bit 3 queues message 303 on current protection fault.
// - Current bit 2 forces output off on current protection fault.
// - Current bit 1 makes current mode measurement fault a device error.
// - Current bit 0 shuts output on current mode measurement fault.
// - Current word query returns the stored byte.
// - Voltage bit 7 applies the fixed voltage limit while output is on.
// - Voltage bit 6 enables voltage protection fault detection.
// - Voltage bit 3 queues message 304 on voltage protection fault, unless message 303 goes out in the same cycle.
// - Voltage bit 2 forces output off on voltage protection fault.
// - Voltage bit 1 makes voltage mode measurement fault a device error.
// - Voltage bit 0 lets that device error also switch output off.
// - Voltage word query returns the stored byte.
// - On-state current limit value defaults zero, applied only with bit 7.
// - Writes take effect at once and hold until reset or reload.
module per_top (
    // Clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst,
    // Command port
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    input  wire logic [1:0] i_sel,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_ese_init,
    output logic      [7:0] o_rdata,
    output logic            o_rvalid,
    // Power stage status
    input  wire logic       i_output_on,
    input  wire logic       i_curr_mode,
    input  wire logic       i_curr_prot_fault,
    input  wire logic       i_volt_prot_fault,
    input  wire logic       i_curr_meas_fault,
    input  wire logic       i_volt_meas_fault,
    // Limit and shutdown controls
    output logic            o_curr_limit_fixed,
    output logic            o_volt_limit_fixed,
    output logic      [7:0] o_curr_limit_value,
    output logic            o_force_off,
    // Status and message reporting
    output logic            o_esr_curr_prot,
    output logic      [7:0] o_ese_load,
    output logic            o_ese_load_stb,
    output logic            o_msg_valid,
    output logic      [9:0] o_msg_code,
    output logic            o_dev_err
);

    logic [7:0] curr_resp_r;
    logic [7:0] volt_resp_r;
    logic [7:0] on_limit_r;
    logic       curr_prot_det;
    logic       volt_prot_det;
    logic       curr_meas_det;
    logic       volt_meas_det;

    // Response words update on the cycle of the write
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            curr_resp_r <= per_pkg::RESP_RESET;
            volt_resp_r <= per_pkg::RESP_RESET;
            on_limit_r  <= per_pkg::LIMIT_RESET;
        end else if (i_wr) begin
            case (i_sel)
                per_pkg::SEL_CURR_RESP: curr_resp_r <= i_wdata;
                per_pkg::SEL_VOLT_RESP: volt_resp_r <= i_wdata;
                per_pkg::SEL_ON_LIMIT:  on_limit_r  <= i_wdata;
                default: ;
            endcase
        end
    end

    // Query answer, one byte a cycle after the read
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_rdata  <= 8'h00;
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= i_rd;
            if (i_rd) begin
                case (i_sel)
                    per_pkg::SEL_CURR_RESP: o_rdata <= curr_resp_r;
                    per_pkg::SEL_VOLT_RESP: o_rdata <= volt_resp_r;
                    per_pkg::SEL_ON_LIMIT:  o_rdata <= on_limit_r;
                    default:                o_rdata <= 8'h00;
                endcase
            end
        end
    end

    // Protection detection gated by its own enable; measurement faults have no enable and count only in the matching mode
    assign curr_prot_det = i_curr_prot_fault & curr_resp_r[per_pkg::BIT_PROT_EN];
    assign volt_prot_det = i_volt_prot_fault & volt_resp_r[per_pkg::BIT_PROT_EN];
    assign curr_meas_det = i_curr_meas_fault & i_curr_mode;
    assign volt_meas_det = i_volt_meas_fault & ~i_curr_mode;

    // Limit selection is combinational so a word change shows at once
    assign o_curr_limit_fixed = i_output_on & curr_resp_r[per_pkg::BIT_FIX_LIMIT];
    assign o_volt_limit_fixed = i_output_on & volt_resp_r[per_pkg::BIT_FIX_LIMIT];

    // Limit value is zero unless the fixed level is selected
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_curr_limit_value <= 8'h00;
        end else begin
            o_curr_limit_value <= curr_resp_r[per_pkg::BIT_FIX_LIMIT] ? on_limit_r
                                                                      : 8'h00;
        end
    end

    // Output off request is sticky until reset; software restores output via power stage
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_force_off <= 1'b0;
        end else if ((curr_prot_det & curr_resp_r[per_pkg::BIT_PROT_OFF])
                   | (volt_prot_det & volt_resp_r[per_pkg::BIT_PROT_OFF])
                   | (curr_meas_det & curr_resp_r[per_pkg::BIT_MEAS_OFF])
                   | (volt_meas_det & volt_resp_r[per_pkg::BIT_MEAS_MSG]
                                    & volt_resp_r[per_pkg::BIT_MEAS_OFF])) begin
            o_force_off <= 1'b1;
        end
    end

    // Event status flag pulses, the status register outside holds it
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_esr_curr_prot <= 1'b0;
        end else begin
            o_esr_curr_prot <= curr_prot_det & curr_resp_r[per_pkg::BIT_ESR_EN];
        end
    end

    // Event enable preset offered on each init request while current bit 4 is set
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_ese_load     <= 8'h00;
            o_ese_load_stb <= 1'b0;
        end else begin
            o_ese_load_stb <= i_ese_init & curr_resp_r[per_pkg::BIT_ESE_INIT];
            if (i_ese_init) begin
                o_ese_load <= curr_resp_r[per_pkg::BIT_ESR_EN] ? per_pkg::ESE_INIT_PROT
                                                               : per_pkg::ESE_INIT_PLAIN;
            end
        end
    end

    // Messages; current fault wins when both arrive together, a rare coincidence
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_msg_valid <= 1'b0;
            o_msg_code  <= 10'h000;
        end else begin
            o_msg_valid <= 1'b0;
            if (curr_prot_det & curr_resp_r[per_pkg::BIT_MSG_EN]) begin
                o_msg_valid <= 1'b1;
                o_msg_code  <= per_pkg::MSG_CURR_PROT;
            end else if (volt_prot_det & volt_resp_r[per_pkg::BIT_MSG_EN]) begin
                o_msg_valid <= 1'b1;
                o_msg_code  <= per_pkg::MSG_VOLT_PROT;
            end
        end
    end

    // Device error pulse for measurement faults
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_dev_err <= 1'b0;
        end else begin
            o_dev_err <= (curr_meas_det & curr_resp_r[per_pkg::BIT_MEAS_MSG])
                       | (volt_meas_det & volt_resp_r[per_pkg::BIT_MEAS_MSG]);
        end
    end

    // Checks on storage and query. A write is checked one edge later, so a byte
    // dropped behind a same-cycle read would show here before any status logic.
    a_write_holds: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_wr && i_sel == per_pkg::SEL_CURR_RESP)
        |=> (curr_resp_r == $past(i_wdata)))
        else $error("current word not stored");

    a_volt_store: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_wr && i_sel == per_pkg::SEL_VOLT_RESP)
        |=> (volt_resp_r == $past(i_wdata)))
        else $error("voltage word not stored");

    a_query_curr: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_rd && !i_wr && i_sel == per_pkg::SEL_CURR_RESP)
        |=> (o_rvalid && o_rdata == curr_resp_r))
        else $error("current query wrong");

    a_query_volt: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_rd && !i_wr && i_sel == per_pkg::SEL_VOLT_RESP)
        |=> (o_rvalid && o_rdata == volt_resp_r))
        else $error("voltage query wrong");

    a_query_limit: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_rd && !i_wr && i_sel == per_pkg::SEL_ON_LIMIT)
        |=> (o_rvalid && o_rdata == on_limit_r))
        else $error("limit query wrong");

    a_query_none: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_rd && i_sel == 2'h3)
        |=> (o_rvalid && o_rdata == 8'h00))
        else $error("unused select answered");

    a_rvalid_once: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !i_rd
        |=> !o_rvalid)
        else $error("answer without a query");

    // Limit selection follows the words and the output state
    a_fix_limit: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        o_curr_limit_fixed == (i_output_on && curr_resp_r[per_pkg::BIT_FIX_LIMIT]))
        else $error("current limit select wrong");

    a_volt_fix: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        o_volt_limit_fixed == (i_output_on && volt_resp_r[per_pkg::BIT_FIX_LIMIT]))
        else $error("voltage limit select wrong");

    a_limit_on: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        curr_resp_r[per_pkg::BIT_FIX_LIMIT]
        |=> (o_curr_limit_value == $past(on_limit_r)))
        else $error("limit value not applied");

    a_limit_off: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !curr_resp_r[per_pkg::BIT_FIX_LIMIT]
        |=> (o_curr_limit_value == 8'h00))
        else $error("limit value applied without bit 7");

    // Protection faults: each action hangs on its own enable bit
    a_prot_gate: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (!curr_resp_r[per_pkg::BIT_PROT_EN] && !volt_resp_r[per_pkg::BIT_PROT_EN])
        |=> (!o_msg_valid && !o_esr_curr_prot))
        else $error("detection not gated");

    a_esr_flag: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_curr_prot_fault && curr_resp_r[per_pkg::BIT_PROT_EN]
                           && curr_resp_r[per_pkg::BIT_ESR_EN])
        |=> o_esr_curr_prot)
        else $error("status flag missing");

    a_esr_quiet: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !(i_curr_prot_fault && curr_resp_r[per_pkg::BIT_PROT_EN]
                            && curr_resp_r[per_pkg::BIT_ESR_EN])
        |=> !o_esr_curr_prot)
        else $error("status flag without fault");

    a_msg_303: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_curr_prot_fault && curr_resp_r[per_pkg::BIT_PROT_EN]
                           && curr_resp_r[per_pkg::BIT_MSG_EN])
        |=> (o_msg_valid && o_msg_code == per_pkg::MSG_CURR_PROT))
        else $error("message 303 missing");

    a_msg_304: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_volt_prot_fault && volt_resp_r[per_pkg::BIT_PROT_EN]
                           && volt_resp_r[per_pkg::BIT_MSG_EN]
                           && !(i_curr_prot_fault && curr_resp_r[per_pkg::BIT_PROT_EN]
                                                  && curr_resp_r[per_pkg::BIT_MSG_EN]))
        |=> (o_msg_valid && o_msg_code == per_pkg::MSG_VOLT_PROT))
        else $error("message 304 missing");

    a_msg_quiet: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (!i_curr_prot_fault && !i_volt_prot_fault)
        |=> !o_msg_valid)
        else $error("message without fault");

    a_off_curr: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_curr_prot_fault && curr_resp_r[per_pkg::BIT_PROT_EN]
                           && curr_resp_r[per_pkg::BIT_PROT_OFF])
        |=> o_force_off)
        else $error("output not forced off");

    a_off_volt: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_volt_prot_fault && volt_resp_r[per_pkg::BIT_PROT_EN]
                           && volt_resp_r[per_pkg::BIT_PROT_OFF])
        |=> o_force_off)
        else $error("voltage fault left output on");

    a_off_sticky: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        o_force_off
        |=> o_force_off)
        else $error("output off request dropped");

    a_off_cause: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (!o_force_off && !i_curr_prot_fault && !i_volt_prot_fault
                      && !i_curr_meas_fault && !i_volt_meas_fault)
        |=> !o_force_off)
        else $error("output off without fault");

    // Measurement faults count only in the matching regulation mode
    a_meas_curr: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_curr_meas_fault && i_curr_mode && curr_resp_r[per_pkg::BIT_MEAS_MSG])
        |=> o_dev_err)
        else $error("current device error missing");

    a_meas_mode: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_curr_meas_fault && !i_curr_mode && !i_volt_meas_fault)
        |=> !o_dev_err)
        else $error("current fault counted in voltage mode");

    a_meas_off: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_curr_meas_fault && i_curr_mode && curr_resp_r[per_pkg::BIT_MEAS_OFF])
        |=> o_force_off)
        else $error("current fault left output on");

    a_meas_volt: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_volt_meas_fault && !i_curr_mode && volt_resp_r[per_pkg::BIT_MEAS_MSG])
        |=> o_dev_err)
        else $error("voltage device error missing");

    a_volt_off: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (volt_meas_det && volt_resp_r[per_pkg::BIT_MEAS_MSG]
                       && volt_resp_r[per_pkg::BIT_MEAS_OFF])
        |=> (o_force_off && o_dev_err))
        else $error("voltage device error not off");

    a_volt_bit0: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (!o_force_off && !volt_resp_r[per_pkg::BIT_MEAS_MSG]
                      && !i_curr_prot_fault && !i_volt_prot_fault && !i_curr_meas_fault)
        |=> !o_force_off)
        else $error("voltage bit 0 acted alone");

    a_err_quiet: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (!i_curr_meas_fault && !i_volt_meas_fault)
        |=> !o_dev_err)
        else $error("device error without fault");

    // Event enable preset only on an init request with bit 4 set
    a_ese_value: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_ese_init && curr_resp_r[per_pkg::BIT_ESE_INIT])
        |=> (o_ese_load_stb && o_ese_load == ($past(curr_resp_r[per_pkg::BIT_ESR_EN])
                                               ? per_pkg::ESE_INIT_PROT
                                               : per_pkg::ESE_INIT_PLAIN)))
        else $error("event enable preset wrong");

    a_ese_quiet: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !(i_ese_init && curr_resp_r[per_pkg::BIT_ESE_INIT])
        |=> !o_ese_load_stb)
        else $error("event enable preset without request");

endmodule : per_top

/* File: bench/per_stage_model.sv */
// Purpose: Power stage stand-in giving mode levels and fault pulses.
// Assumes: Requests from the bench change just after a rising edge.
// Notes:   Fault bits: 0 curr prot, 1 volt prot, 2 curr meas, 3 volt meas.
module per_stage_model (
    // Clock
    input  wire logic       i_clk_sys,
    // Requests from the bench
    input  wire logic       i_on_req,
    input  wire logic       i_cmode_req,
    input  wire logic [3:0] i_fault_req,
    // Stage status
    output logic            o_output_on,
    output logic            o_curr_mode,
    output logic      [3:0] o_fault
);
    timeunit 1ns;
    timeprecision 1ns;
    // Output off, current mode, quiet after power-up
    logic       on_r    = 1'b0;
    logic       cmode_r = 1'b1;
    logic [3:0] fault_r = 4'h0;
    logic [3:0] seen_r  = 4'h0;
    // Levels follow on the edge; a raised request gives one pulse only,
    // since a held fault would hide a missing one-shot in the block
    always @(posedge i_clk_sys) begin
        on_r    <= i_on_req;
        cmode_r <= i_cmode_req;
        fault_r <= i_fault_req & ~seen_r;
        seen_r  <= i_fault_req;
    end
    assign o_output_on = on_r;
    assign o_curr_mode = cmode_r;
    assign o_fault     = fault_r;
endmodule : per_stage_model

/* File: bench/tb_top.sv */
// Purpose: Self-checking bench for the fault response block.
// Assumes: Command strobes last one cycle; results show one edge later.
// Notes:   Output shutdown is sticky, so a reset separates scenarios.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic       i_clk_sys, i_rst, i_wr, i_rd, i_ese_init, on, cmode;
    logic [1:0] i_sel;
    logic [7:0] i_wdata, rdata, lim_val, ese_load;
    logic [3:0] flt, fault_req;
    logic       on_req, cmode_req;
    logic       rvalid, cfix, vfix, foff, esr, ese_stb, msg_v, dev_err;
    logic [9:0] msg_code;
    int         n_fail, check_count;
    per_top per_top_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_wr(i_wr), .i_rd(i_rd),
        .i_sel(i_sel), .i_wdata(i_wdata), .i_ese_init(i_ese_init), .o_rdata(rdata),
        .o_rvalid(rvalid), .i_output_on(on), .i_curr_mode(cmode),
        .i_curr_prot_fault(flt[0]), .i_volt_prot_fault(flt[1]),
        .i_curr_meas_fault(flt[2]), .i_volt_meas_fault(flt[3]),
        .o_curr_limit_fixed(cfix), .o_volt_limit_fixed(vfix),
        .o_curr_limit_value(lim_val), .o_force_off(foff), .o_esr_curr_prot(esr),
        .o_ese_load(ese_load), .o_ese_load_stb(ese_stb), .o_msg_valid(msg_v),
        .o_msg_code(msg_code), .o_dev_err(dev_err));
    per_stage_model per_stage_model_inst (.i_clk_sys(i_clk_sys), .i_on_req(on_req),
        .i_cmode_req(cmode_req), .i_fault_req(fault_req), .o_output_on(on),
        .o_curr_mode(cmode), .o_fault(flt));
    // Free-running 125 MHz clock
    initial begin
        i_clk_sys = 1'b0;
        forever #4 i_clk_sys = ~i_clk_sys;
    end
    task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude
    task automatic reset_dut(input int n);
        i_rst = 1'b1;
        repeat (n) @(posedge i_clk_sys);
        #1 i_rst = 1'b0;
    endtask : reset_dut
    task automatic wr(input logic [1:0] sel, input logic [7:0] d);
        @(posedge i_clk_sys) #1;
        i_wr = 1'b1;
        i_sel = sel;
        i_wdata = d;
        @(posedge i_clk_sys) #1;
        i_wr = 1'b0;
    endtask : wr
    // Query answer is sampled in its single valid cycle
    task automatic rd(input logic [1:0] sel, input logic [7:0] exp);
        @(posedge i_clk_sys) #1;
        i_rd = 1'b1;
        i_sel = sel;
        @(posedge i_clk_sys) #1;
        i_rd = 1'b0;
        chk("rvalid", 10'h001, {9'h0, rvalid});
        chk("rdata", {2'h0, exp}, {2'h0, rdata});
    endtask : rd
    task automatic ese(input logic [7:0] w, input logic stb, input logic [7:0] val);
        wr(2'h0, w);
        @(posedge i_clk_sys) #1;
        i_ese_init = 1'b1;
        @(posedge i_clk_sys) #1;
        i_ese_init = 1'b0;
        chk("ese_stb", {9'h0, stb}, {9'h0, ese_stb});
        if (stb) chk("ese_load", {2'h0, val}, {2'h0, ese_load});
    endtask : ese
    // Stage levels take effect at the model's next edge
    task automatic set_state(input logic on_lvl, input logic cmode_lvl);
        @(posedge i_clk_sys) #1;
        on_req = on_lvl;
        cmode_req = cmode_lvl;
        @(posedge i_clk_sys) #1;
    endtask : set_state
    // Fault shows one edge after the request, the block answers one edge later
    task automatic pulse(input logic [3:0] f);
        @(posedge i_clk_sys) #1;
        fault_req = f;
        @(posedge i_clk_sys) #1;
        fault_req = 4'h0;
        @(posedge i_clk_sys) #1;
    endtask : pulse
    // Hang guard
    initial begin
        repeat (20000) @(posedge i_clk_sys);
        n_fail++;
        conclude();
    end
    initial begin
        {i_wr, i_rd, i_ese_init, i_sel, i_wdata, on_req, fault_req} = '0;
        cmode_req = 1'b1;
        reset_dut(16);
        rd(2'h0, 8'h00);
        rd(2'h1, 8'h00);
        wr(2'h0, 8'hff);
        wr(2'h1, 8'h30);
        rd(2'h0, 8'hff);
        rd(2'h1, 8'h30);
        rd(2'h3, 8'h00);
        reset_dut(2);
        wr(2'h2, 8'h33);
        rd(2'h2, 8'h33);
        wr(2'h0, 8'h00);
        set_state(1'b1, 1'b1);
        chk("limit_value", 10'h000, {2'h0, lim_val});
        chk("curr_fixed", 10'h000, {9'h0, cfix});
        wr(2'h0, 8'h80);
        wr(2'h1, 8'h80);
        chk("curr_fixed", 10'h001, {9'h0, cfix});
        chk("volt_fixed", 10'h001, {9'h0, vfix});
        chk("limit_value", 10'h033, {2'h0, lim_val});
        wr(2'h0, 8'h0c);
        pulse(4'h1);
        chk("msg_valid", 10'h000, {9'h0, msg_v});
        chk("force_off", 10'h000, {9'h0, foff});
        wr(2'h0, 8'h6c);
        pulse(4'h1);
        chk("msg_valid", 10'h001, {9'h0, msg_v});
        chk("msg_code", 10'd303, msg_code);
        chk("esr", 10'h001, {9'h0, esr});
        chk("force_off", 10'h001, {9'h0, foff});
        reset_dut(2);
        wr(2'h1, 8'h0c);
        pulse(4'h2);
        chk("msg_valid", 10'h000, {9'h0, msg_v});
        chk("force_off", 10'h000, {9'h0, foff});
        wr(2'h1, 8'h48);
        pulse(4'h2);
        chk("msg_code", 10'd304, msg_code);
        chk("force_off", 10'h000, {9'h0, foff});
        wr(2'h1, 8'h44);
        pulse(4'h2);
        chk("force_off", 10'h001, {9'h0, foff});
        ese(8'h30, 1'b1, 8'd72);
        ese(8'h10, 1'b1, 8'd8);
        ese(8'h20, 1'b0, 8'd0);
        reset_dut(2);
        wr(2'h0, 8'h02);
        pulse(4'h4);
        chk("dev_err", 10'h001, {9'h0, dev_err});
        chk("force_off", 10'h000, {9'h0, foff});
        wr(2'h0, 8'h01);
        pulse(4'h4);
        chk("force_off", 10'h001, {9'h0, foff});
        reset_dut(2);
        set_state(1'b1, 1'b0);
        wr(2'h1, 8'h02);
        pulse(4'h8);
        chk("dev_err", 10'h001, {9'h0, dev_err});
        chk("force_off", 10'h000, {9'h0, foff});
        wr(2'h1, 8'h03);
        pulse(4'h8);
        chk("force_off", 10'h001, {9'h0, foff});
        conclude();
    end
endmodule : tb_top
